// File: hdl/dms_burst_order.sv
// beat order and driver float mask for a burst
`default_nettype none
module dms_burst_order (
    // burst request
    input  wire logic [2:0]  start,
    input  wire logic        ilv,
    input  wire logic        chop,
    input  wire logic        is_wr,
    // per-beat column index and float flag
    output logic      [23:0] order,
    output logic      [7:0]  hiz
);
    genvar b;
    // each read beat: sequential wraps in the nibble, interleave xors the start
    for (b = 0; b < 8; b++) begin : g_beat
        localparam logic [2:0] B = 3'(b);
        logic [2:0] rd;
        assign rd = ilv ? (start ^ B) : {start[2] ^ B[2], 2'(start[1:0] + B[1:0])};
        assign order[3*b +: 3] = is_wr ? (chop ? {start[2], B[1:0]} : B) : rd;
        assign hiz[b] = chop & ~is_wr & B[2];
    end
endmodule : dms_burst_order
`default_nettype wire

// File: hdl/dms_init_seq.sv
// ddr3 power-up, reset and mode register tracker with axi4-lite status
// How it works
// - cke stays low 500 us after reset release for internal init.
// - termination stays off in reset and until cke registers high.
// - mode set is all strobes low; bank bits pick the register.
// - write recovery field with precharge time forms auto-precharge delay.
// - mpr off means mr3 low bits are ignored; on gives a pattern.
// - burst modes fixed chop-4, fixed eight, or chosen per command.
// - fixed chop-4 writes start internally two clocks early.
// - chosen-per-command chop writes start like a burst of eight.
// - chop-4 reads order four beats by start column, then float.
// - write termination applies on writes; none during write leveling.
// - per-command mode: a12 high picks eight, low picks chop-4.
`include "dms_params.svh"
`default_nettype none
module dms_init_seq import dms_pkg::*; #(
    parameter int unsigned INIT_CYC = `DMS_INIT_CYC
) (
    // bus clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // memory pins
    input  wire logic        mem_ck,
    input  wire logic        mem_reset_n,
    input  wire logic        mem_cke,
    input  wire logic        mem_cs_n,
    input  wire logic        mem_ras_n,
    input  wire logic        mem_cas_n,
    input  wire logic        mem_we_n,
    input  wire logic        mem_odt,
    input  wire logic [2:0]  mem_ba,
    input  wire logic [15:0] mem_a,
    // device state
    output logic             init_done,
    output logic             term_en,
    output logic             wr_early,
    output logic             burst_chop,
    output logic      [23:0] rd_order,
    output logic      [7:0]  rd_hiz,
    // axi4-lite write
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic      [1:0]  s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic      [31:0] s_rdata,
    output logic      [1:0]  s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    localparam int DLL_CK = (`DMS_DLLK_CK > `DMS_ZQINIT_CK) ? `DMS_DLLK_CK : `DMS_ZQINIT_CK;

    // synchronised pins
    logic [26:0] pin_s;
    logic        ck_s, rst_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s;
    logic [2:0]  ba_s;
    logic [15:0] a_s;
    dms_sync #(.W(27)) u_sync (
        .clk   (aclk),
        .rst_n (aresetn),
        .din   ({mem_ck, mem_reset_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n,
                 mem_we_n, mem_odt, mem_ba, mem_a}),
        .dout  (pin_s)
    );
    assign {ck_s, rst_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, ba_s, a_s} = pin_s;

    // sequencer state
    dms_state_t  st_q, st_d;
    logic [16:0] cnt_q, cnt_d;
    logic [4:0]  rcnt_q, rcnt_d;
    logic [9:0]  ckc_q, ckc_d;
    logic        ck_p_q, nop_q, nop_d, ckeh_q, ckeh_d, odt_r_q, odt_r_d;
    logic [15:0] mr_q [4];
    logic [15:0] mr_d [4];
    logic        chop_q, chop_d, isw_q, isw_d, early_q, early_d, term_q, term_d;
    logic [2:0]  start_q, start_d, wact_q, wact_d;
    logic [23:0] ord_q, ord_w;
    logic [7:0]  hiz_q, hiz_w;
    logic [5:0]  tdal_q, tdal_d;
    logic        done_q;
    logic [10:0] err_set;
    // bus state
    logic [10:0] err_q, err_d;
    logic [4:0]  trp_q, trp_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic        awf_q, awf_d, wf_q, wf_d, awr_q, awr_d, wr_q, wr_d;
    logic        bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;

    // command decode on the sampled memory clock edge
    logic    ck_rise, nop, mrs, zqcl, rdwr, post_cke, mrs_ok, rsv_bad;
    dms_bl_t bl;
    assign ck_rise  = ck_s & ~ck_p_q;
    assign nop      = cs_s | (ras_s & cas_s & we_s);
    assign mrs      = ~cs_s & ~ras_s & ~cas_s & ~we_s;
    assign zqcl     = ~cs_s & ras_s & cas_s & ~we_s & a_s[`DMS_A_AP];
    assign rdwr     = ~cs_s & ras_s & ~cas_s;
    assign bl       = dms_bl_t'(mr_q[0][1:0]);
    assign post_cke = st_q inside {ST_XPR, ST_MR2, ST_MR3, ST_MR1, ST_MR0, ST_ZQ, ST_DLL};
    // expected register of each load step, with the dll bit for mr1 and mr0
    always_comb begin
        unique case (st_q)
            ST_MR2:  mrs_ok = (ba_s == 3'h2);
            ST_MR3:  mrs_ok = (ba_s == 3'h3);
            ST_MR1:  mrs_ok = (ba_s == 3'h1) & ~a_s[`DMS_MR1_DLLDIS];
            ST_MR0:  mrs_ok = (ba_s == 3'h0) & a_s[`DMS_MR0_DLLRST];
            default: mrs_ok = 1'b0;
        endcase
    end
    // reserved bits per selected register
    always_comb begin
        unique case (ba_s[1:0])
            2'h0: rsv_bad = |(a_s & `DMS_RSV_MR0);
            2'h1: rsv_bad = |(a_s & `DMS_RSV_MR1);
            2'h2: rsv_bad = |(a_s & `DMS_RSV_MR2);
            2'h3: rsv_bad = |(a_s & `DMS_RSV_MR3);
        endcase
        rsv_bad = rsv_bad | ba_s[2];
    end

    // sequencer next state
    always_comb begin
        st_d = st_q; cnt_d = cnt_q; rcnt_d = rcnt_q; ckc_d = ckc_q; nop_d = nop_q;
        ckeh_d = ckeh_q; odt_r_d = odt_r_q; mr_d = mr_q; chop_d = chop_q;
        isw_d = isw_q; early_d = early_q; start_d = start_q; wact_d = wact_q;
        err_set = 11'h000;
        if (ck_rise && wact_q != 3'h0) wact_d = wact_q - 3'h1;
        if (ck_rise && ckc_q != 10'h3ff) ckc_d = ckc_q + 10'h001;
        if (!rst_s) begin
            st_d = ST_RESET;
            ckeh_d = 1'b0;
            if (rcnt_q != 5'h1f) rcnt_d = rcnt_q + 5'h01;
        end else begin
            unique case (st_q)
                ST_RESET: begin
                    err_set[8] = (rcnt_q < 5'(`DMS_RST_CYC));
                    err_set[1] = cke_s;
                    st_d = ST_INTINIT; cnt_d = '0; ckc_d = '0; nop_d = 1'b0; rcnt_d = '0;
                end
                ST_INTINIT: begin
                    err_set[0] = cke_s;
                    cnt_d = cnt_q + 17'h00001;
                    if (cnt_q == 17'(INIT_CYC - 1)) st_d = ST_WAIT_CKE;
                    if (ck_rise && nop) nop_d = 1'b1;
                end
                ST_WAIT_CKE: begin
                    if (ck_rise && !cke_s && nop) nop_d = 1'b1;
                    if (ck_rise && cke_s) begin
                        err_set[2]  = ~nop_q;
                        err_set[10] = (ckc_q < 10'(`DMS_CKSTAB_CK));
                        ckeh_d = 1'b1; odt_r_d = odt_s; cnt_d = '0; st_d = ST_XPR;
                    end
                end
                ST_XPR: if (ck_rise) begin
                    err_set[5] = mrs & ~cs_s;
                    cnt_d = cnt_q + 17'h00001;
                    if (cnt_q == 17'(`DMS_XPR_CK - 2)) st_d = ST_MR2;
                end
                ST_MR2, ST_MR3, ST_MR1, ST_MR0: if (ck_rise && !nop) begin
                    err_set[6] = ~(mrs & mrs_ok);
                    if (mrs && mrs_ok) st_d = dms_state_t'(st_q + 4'h1);
                end
                ST_ZQ: if (ck_rise && !nop) begin
                    err_set[6] = ~zqcl;
                    if (zqcl) begin st_d = ST_DLL; cnt_d = '0; end
                end
                ST_DLL: if (ck_rise) begin
                    err_set[6] = ~nop;
                    cnt_d = cnt_q + 17'h00001;
                    if (cnt_q == 17'(DLL_CK - 1)) st_d = ST_READY;
                end
                ST_READY: if (ck_rise && rdwr) begin
                    isw_d   = ~we_s;
                    start_d = a_s[2:0];
                    chop_d  = (bl == BL_FIX4) | ((bl == BL_OTF) & ~a_s[`DMS_A_BC]);
                    early_d = ~we_s & (bl == BL_FIX4);
                    if (!we_s) wact_d = 3'(`DMS_WR_ACT_CK);
                end
            endcase
            if (post_cke && ck_rise) begin
                err_set[3] = ~cke_s;
                err_set[4] = odt_s ^ odt_r_q;
            end
            if (ck_rise && mrs && !cs_s && st_q inside {ST_MR2, ST_MR3, ST_MR1, ST_MR0,
                                                         ST_ZQ, ST_DLL, ST_READY}) begin
                mr_d[ba_s[1:0]] = a_s;
                err_set[7] = rsv_bad;
                err_set[9] = (ba_s[1:0] == 2'h0) & (a_s[1:0] == 2'h3);
            end
        end
    end

    // derived outputs: termination, auto-precharge delay, burst order
    logic rtt_nom_on, rtt_wr_on, wlvl, mpr_en;
    logic [1:0] mpr_loc;
    assign rtt_nom_on = |(mr_q[1] & `DMS_RTT_NOM_M);
    assign rtt_wr_on  = |(mr_q[2] & `DMS_RTT_WR_M);
    assign wlvl       = mr_q[1][`DMS_MR1_WLVL];
    assign mpr_en     = mr_q[3][`DMS_MR3_MPR];
    assign mpr_loc    = mpr_en ? mr_q[3][1:0] : 2'h0;
    // termination is off until cke is registered high after reset
    assign term_d = ckeh_d & ((odt_s & rtt_nom_on) |
                    ((wact_q != 3'h0) & rtt_wr_on & ~wlvl));
    assign tdal_d = 6'(mr_q[0][11:`DMS_MR0_WR_LO]) + 6'(trp_q);
    dms_burst_order u_ord (
        .start (start_q),
        .ilv   (mr_q[0][`DMS_MR0_BT]),
        .chop  (chop_q),
        .is_wr (isw_q),
        .order (ord_w),
        .hiz   (hiz_w)
    );

    // sequencer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_RESET; cnt_q <= '0; rcnt_q <= '0; ckc_q <= '0; ck_p_q <= 1'b0;
            nop_q <= 1'b0; ckeh_q <= 1'b0; odt_r_q <= 1'b0;
            for (int i = 0; i < 4; i++) mr_q[i] <= 16'h0000;
            chop_q <= 1'b0; isw_q <= 1'b0; early_q <= 1'b0; start_q <= 3'h0;
            wact_q <= 3'h0; term_q <= 1'b0; tdal_q <= 6'h00; ord_q <= 24'h000000;
            hiz_q <= 8'h00; done_q <= 1'b0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; rcnt_q <= rcnt_d; ckc_q <= ckc_d;
            ck_p_q <= ck_s; nop_q <= nop_d; ckeh_q <= ckeh_d; odt_r_q <= odt_r_d;
            mr_q <= mr_d; chop_q <= chop_d; isw_q <= isw_d; early_q <= early_d;
            start_q <= start_d; wact_q <= wact_d; term_q <= term_d; tdal_q <= tdal_d;
            ord_q <= ord_w; hiz_q <= hiz_w;
            done_q <= (st_d == ST_READY); // ready flag from its own flop
        end
    end
    assign init_done  = done_q;
    assign term_en    = term_q;
    assign wr_early   = early_q;
    assign burst_chop = chop_q;
    assign rd_order   = ord_q;
    assign rd_hiz     = hiz_q;

    // axi4-lite slave next state; errors are write-one-to-clear, set wins
    logic aw_t, w_t, do_w, clr;
    always_comb begin
        aw_t = s_awvalid & awr_q;
        w_t  = s_wvalid & wr_q;
        awa_d = aw_t ? s_awaddr : awa_q;
        wd_d  = w_t ? s_wdata : wd_q;
        ws_d  = w_t ? s_wstrb : ws_q;
        awf_d = awf_q | aw_t;
        wf_d  = wf_q | w_t;
        bv_d  = bv_q & ~s_bready;
        br_d  = br_q;
        trp_d = trp_q;
        clr   = 1'b0;
        do_w  = awf_d & wf_d & ~bv_q;
        if (do_w) begin
            awf_d = 1'b0; wf_d = 1'b0; bv_d = 1'b1; br_d = 2'b00;
            if (awa_d == `DMS_REG_CTRL) begin
                if (ws_d[0]) trp_d = wd_d[4:0];
            end else if (awa_d == `DMS_REG_ERR) begin
                clr = 1'b1;
            end else begin
                br_d = 2'b10;
            end
        end
        err_d = (err_q & ~(clr ? ({ws_d[1], ws_d[1], ws_d[1], {8{ws_d[0]}}} & wd_d[10:0])
                                : 11'h000)) | err_set;
        awr_d = ~awf_d & ~bv_d;
        wr_d  = ~wf_d & ~bv_d;
        rv_d  = rv_q & ~s_rready;
        rd_d  = rd_q;
        rr_d  = rr_q;
        if (s_arvalid && arr_q) begin
            rv_d = 1'b1; rr_d = 2'b00;
            unique case (s_araddr)
                `DMS_REG_CTRL:   rd_d = {27'h0, trp_q};
                `DMS_REG_STATUS: rd_d = {22'h0, mpr_loc, mpr_en, term_q, (st_q == ST_READY),
                                         1'b0, st_q};
                `DMS_REG_MR0:    rd_d = {16'h0, mr_q[0]};
                `DMS_REG_MR1:    rd_d = {16'h0, mr_q[1]};
                `DMS_REG_MR2:    rd_d = {16'h0, mr_q[2]};
                `DMS_REG_MR3:    rd_d = {16'h0, mr_q[3]};
                `DMS_REG_BURST:  rd_d = {20'h0, tdal_q, early_q, isw_q, chop_q, start_q};
                `DMS_REG_ERR:    rd_d = {21'h0, err_q};
                default: begin
                    rd_d = 32'h0000_0000; rr_d = 2'b10;
                end
            endcase
        end
        arr_d = ~rv_d;
    end

    // axi4-lite slave registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 11'h000; trp_q <= `DMS_TRP_RST; awa_q <= 8'h00; wd_q <= 32'h0;
            ws_q <= 4'h0; awf_q <= 1'b0; wf_q <= 1'b0; awr_q <= 1'b0; wr_q <= 1'b0;
            bv_q <= 1'b0; br_q <= 2'b00; arr_q <= 1'b0; rv_q <= 1'b0; rd_q <= 32'h0;
            rr_q <= 2'b00;
        end else begin
            err_q <= err_d; trp_q <= trp_d; awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d;
            awf_q <= awf_d; wf_q <= wf_d; awr_q <= awr_d; wr_q <= wr_d; bv_q <= bv_d;
            br_q <= br_d; arr_q <= arr_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
        end
    end
    assign s_awready = awr_q;
    assign s_wready  = wr_q;
    assign s_bvalid  = bv_q;
    assign s_bresp   = br_q;
    assign s_arready = arr_q;
    assign s_rvalid  = rv_q;
    assign s_rdata   = rd_q;
    assign s_rresp   = rr_q;

    // checks on the sequencer and burst logic
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_term_in_reset: assert property (st_q == ST_RESET |=> !term_q)
        else $error("termination on during reset");
    a_early_cke: assert property ((st_q == ST_INTINIT) && rst_s && cke_s |=> err_q[0])
        else $error("cke during internal init not flagged");
    a_mr_order: assert property (ck_rise && rst_s && st_q == ST_MR2 && mrs && ba_s == 3'h2
        |=> st_q == ST_MR3 ##0 mr_q[2] == $past(a_s))
        else $error("mr2 load did not advance to mr3");
    a_mrs_decode: assert property (ck_rise && rst_s && st_q == ST_READY && mrs &&
        ba_s == 3'h1 |=> mr_q[1] == $past(a_s))
        else $error("mrs to mr1 not stored");
    a_dal_sum: assert property (aresetn |=> tdal_q == 6'($past(mr_q[0][11:9])) + 6'($past(trp_q)))
        else $error("auto-precharge delay wrong");
    a_mpr_ignore: assert property (!mpr_en |-> mpr_loc == 2'h0)
        else $error("mpr location visible while mpr off");
    a_otf_select: assert property (ck_rise && rst_s && st_q == ST_READY && rdwr &&
        bl == BL_OTF |=> chop_q == !$past(a_s[12]))
        else $error("per-command chop select wrong");
    a_fix4_early: assert property (ck_rise && rst_s && st_q == ST_READY && rdwr && !we_s
        |=> early_q == ($past(bl) == BL_FIX4))
        else $error("write early start wrong");
    a_chop_float: assert property (chop_q && !isw_q |=> hiz_q == 8'hf0)
        else $error("chop read beats not floated");
    a_wr_term: assert property (ckeh_q && rst_s && wact_q != 3'h0 && rtt_wr_on && !wlvl
        |=> term_q)
        else $error("write termination missing");
    c_ready: cover property (st_q == ST_DLL ##1 st_q == ST_READY);
    c_chop_rd: cover property (chop_q && !isw_q);
    c_err_clr: cover property (err_q != 11'h000 ##[1:50] err_q == 11'h000);
endmodule : dms_init_seq
`default_nettype wire

// File: hdl/dms_params.svh
// constants for the ddr3 init and mode setup tracker
`ifndef DMS_PARAMS_SVH
`define DMS_PARAMS_SVH
// register byte offsets
`define DMS_REG_CTRL    8'h00
`define DMS_REG_STATUS  8'h04
`define DMS_REG_MR0     8'h08
`define DMS_REG_MR1     8'h0c
`define DMS_REG_MR2     8'h10
`define DMS_REG_MR3     8'h14
`define DMS_REG_BURST   8'h18
`define DMS_REG_ERR     8'h1c
// reset values
`define DMS_TRP_RST     5'h05
// timing: bus clock period and documented times
`define DMS_CLK_NS      5
`define DMS_T_INIT_US   500
`define DMS_INIT_CYC    ((`DMS_T_INIT_US * 1000) / `DMS_CLK_NS)
`define DMS_T_RST_NS    100
`define DMS_RST_CYC     ((`DMS_T_RST_NS + `DMS_CLK_NS - 1) / `DMS_CLK_NS)
`define DMS_CKSTAB_CK   5
`define DMS_XPR_CK      5
`define DMS_DLLK_CK     512
`define DMS_ZQINIT_CK   512
`define DMS_WR_ACT_CK   4
// mode register field positions
`define DMS_MR0_BT      3
`define DMS_MR0_DLLRST  8
`define DMS_MR0_WR_LO   9
`define DMS_MR1_DLLDIS  0
`define DMS_MR1_WLVL    7
`define DMS_MR3_MPR     2
`define DMS_A_AP        10
`define DMS_A_BC        12
// reserved address bits per mode register
`define DMS_RSV_MR0     16'he000
`define DMS_RSV_MR1     16'he500
`define DMS_RSV_MR2     16'hf900
`define DMS_RSV_MR3     16'hfff8
// rtt field masks
`define DMS_RTT_NOM_M   16'h0244
`define DMS_RTT_WR_M    16'h0600
`endif

// File: hdl/dms_pkg.sv
// types shared by the ddr3 init and mode setup tracker
`default_nettype none
package dms_pkg;
    typedef enum logic [1:0] {BL_FIX8, BL_OTF, BL_FIX4, BL_RSV} dms_bl_t;
    typedef enum logic [3:0] {
        ST_RESET, ST_INTINIT, ST_WAIT_CKE, ST_XPR, ST_MR2, ST_MR3,
        ST_MR1, ST_MR0, ST_ZQ, ST_DLL, ST_READY
    } dms_state_t;
endpackage : dms_pkg
`default_nettype wire

// File: hdl/dms_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module dms_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // async in, synced out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    genvar i;
    // one two-stage chain per bit; first stage feeds only the second
    for (i = 0; i < W; i++) begin : g_bit
        logic m_q;
        logic s_q;
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                m_q <= 1'b0;
                s_q <= 1'b0;
            end else begin
                m_q <= din[i];
                s_q <= m_q;
            end
        end
        assign dout[i] = s_q;
    end
endmodule : dms_sync
`default_nettype wire

// File: sim/dms_ctl_model.sv
// behavioural ddr3 controller that drives the tracker's memory pins
`default_nettype none
module dms_ctl_model (
    // clock, reset and clock enable
    output logic        mem_ck,
    output logic        mem_reset_n,
    output logic        mem_cke,
    // command, termination and address
    output logic        mem_cs_n,
    output logic        mem_ras_n,
    output logic        mem_cas_n,
    output logic        mem_we_n,
    output logic        mem_odt,
    output logic [2:0]  mem_ba,
    output logic [15:0] mem_a
);
    timeunit 1ns;
    timeprecision 100ps;
    // set once the long power-up reset has been given
    bit warm;
    // memory clock runs all along; reset is held from time zero
    initial begin
        {mem_reset_n, mem_cke, mem_odt} = 3'h0;
        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = 4'hf;
        mem_ba = 3'h0;
        mem_a = 16'h0000;
        mem_ck = 1'b0;
        forever #62.5 mem_ck = ~mem_ck;
    end
    // one command on a rising edge, then n idle edges of nop
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] ad,
                       input int n);
        @(negedge mem_ck);
        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = c;
        mem_ba = b;
        mem_a = ad;
        @(negedge mem_ck);
        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = 4'h7;
        repeat (n) @(negedge mem_ck);
    endtask : cmd
    // reset, init wait, cke, mode loads in order, zq calibration and wait
    task automatic init_seq(input logic [15:0] mr0, input logic [15:0] mr2);
        mem_cke = 1'b0;
        repeat (2) @(negedge mem_ck);
        mem_reset_n = 1'b0;
        repeat (warm ? 3 : 1600) @(negedge mem_ck);
        warm = 1'b1;
        mem_reset_n = 1'b1;
        cmd(4'h7, 3'h0, 16'h0000, 12);
        mem_cke = 1'b1;
        cmd(4'h7, 3'h0, 16'h0000, 5);
        cmd(4'h0, 3'h2, mr2, 0);
        cmd(4'h0, 3'h3, 16'h0000, 0);
        cmd(4'h0, 3'h1, 16'h0000, 0);
        cmd(4'h0, 3'h0, mr0, 0);
        cmd(4'h6, 3'h0, 16'h0400, 520);
    endtask : init_seq
endmodule : dms_ctl_model
`default_nettype wire

// File: sim/dms_init_seq_tb.sv
// self-checking bench for the ddr3 init and mode setup tracker
`default_nettype none
module dms_init_seq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, mem_ck, mem_reset_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n;
    logic mem_we_n, mem_odt, init_done, term_en, wr_early, burst_chop, bt, ilv, ch, bc;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [2:0] mem_ba, s;
    logic [15:0] mem_a, mr0;
    logic [23:0] rd_order, e, msk;
    logic [7:0] rd_hiz, s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    int bad_count, samples_checked, seed, p, k;
    dms_init_seq #(.INIT_CYC(200)) DUT (.aclk, .aresetn, .mem_ck, .mem_reset_n, .mem_cke,
        .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_odt, .mem_ba, .mem_a, .init_done,
        .term_en, .wr_early, .burst_chop, .rd_order, .rd_hiz, .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
        .s_rready);
    dms_ctl_model m (.mem_ck, .mem_reset_n, .mem_cke, .mem_cs_n, .mem_ras_n, .mem_cas_n,
        .mem_we_n, .mem_odt, .mem_ba, .mem_a);
    // bus clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // compare, count and report
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] x);
        samples_checked++;
        if (seen !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, x, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    // bus write, expected response noted first
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        exp_b.push_back(r);
        s_awaddr <= ad;
        s_wdata <= d;
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
    endtask : axi_wr
    // bus read, expected {resp, data} noted first
    task automatic axi_rd(input logic [7:0] ad, input logic [33:0] x);
        @(posedge aclk);
        exp_r.push_back(x);
        s_araddr <= ad;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
    endtask : axi_rd
    // responses taken against the oldest note
    always @(posedge aclk) begin
        if (s_bvalid && s_bready) chk("bresp", {32'h0, s_bresp}, {32'h0, exp_b.pop_front()});
        if (s_rvalid && s_rready) chk("rdata", {s_rresp, s_rdata}, exp_r.pop_front());
    end
    // watchdog
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        seed = 68993;
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("term_en", {33'h0, term_en}, 34'h0);
        axi_rd(8'h00, 34'h5);
        axi_rd(8'h1c, 34'h0);
        axi_rd(8'h20, {2'b10, 32'h0});
        axi_wr(8'h04, 32'h1, 2'b10);
        axi_wr(8'h00, 32'h0a, 2'b00);
        axi_rd(8'h00, 34'h0a);
        $display("test registers done");
        ilv = 1'($random(seed));
        for (p = 0; p < 2; p++) begin
            bt = ilv ^ p[0];
            mr0 = {7'h0, 1'b1, 4'h0, bt, 1'b0, p[0], ~p[0]};
            m.init_seq(mr0, {6'h0, p[0], 9'h0});
            chk("init_done", {33'h0, init_done}, 34'h1);
            axi_rd(8'h08, {18'h0, mr0});
            axi_rd(8'h1c, 34'h0);
            m.cmd(4'h0, 3'h1, 16'h0400, 0);
            axi_rd(8'h1c, 34'h80);
            axi_wr(8'h1c, 32'h80, 2'b00);
            axi_rd(8'h1c, 34'h0);
            repeat (4) begin
                {bc, s} = 4'($random(seed));
                m.cmd(4'h5, 3'h0, {3'h0, bc, 9'h0, s}, 3);
                ch = p[0] | ~bc;
                for (k = 0; k < 8; k++) begin
                    e[3*k+:3] = {s[2] ^ k[2], bt ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0]};
                    msk[3*k+:3] = (ch && k > 3) ? 3'h0 : 3'h7;
                end
                chk("rd_order", {10'h0, rd_order & msk}, {10'h0, e & msk});
                chk("rd_hiz", {26'h0, rd_hiz}, {26'h0, ch ? 8'hf0 : 8'h00});
                chk("burst_chop", {33'h0, burst_chop}, {33'h0, ch});
            end
            m.cmd(4'h4, 3'h0, 16'h0000, 0);
            repeat (8) @(posedge aclk);
            chk("wr_early", {33'h0, wr_early}, {33'h0, p[0]});
            chk("term_en", {33'h0, term_en}, {33'h0, p[0]});
            $display("test init pass %0d done", p);
        end
        wrap_up();
    end
endmodule : dms_init_seq_tb
`default_nettype wire
